/* hdl/reset_and_boot_strap_control.v */
// Operation
// RULE1: Fundamental reset clears all internal logic; prdata is cleared by nrst only, test logic by trst_n only, hold_latched_r takes the hold strap
// RULE2: Hold strap at reset enters quasi-reset
// RULE3: Quasi-reset allows register access, no switching
// RULE4: Clearing hold bit starts normal operation
// RULE5: Mode codes 0 to 3 decoded
// RULE6: Board must not select codes 4-7
// RULE7: Codes 8,9 select reduced latency
// RULE8: Codes A-D multi-partition unattached ports
// RULE9: Codes E,F multi-partition disabled ports
// RULE10: Board keeps mode straps static after reset
// RULE11: Frequency select chooses 100 or 125 MHz
// RULE12: Two-bit strap selects port clocking mode
// RULE13: Each stack strap configures its stack
// RULE14: Test logic clocked only by test clock
// RULE15: Test data output floats when idle
// RULE16: Test reset asynchronously clears test logic
// RULE17: System keeps test reset low normally
// RULE18: Straps captured at reset release, held
`timescale 1ns/1ps
`include "reset_strap_defines.vh"

module reset_and_boot_strap_control #(
	parameter MODE_W = 4,
	parameter CLKSEL_W = 2,
	parameter STACKS = 4
) (
	input wire clk,
	input wire nrst,
	input wire fundamental_reset_n,
	input wire reset_hold_strap,
	input wire [MODE_W-1:0] operating_mode_strap,
	input wire refclk_freq_select,
	input wire [CLKSEL_W-1:0] port_clocking_select,
	input wire [STACKS-1:0] stack_cfg_strap,
	input wire psel,
	input wire penable,
	input wire pwrite,
	input wire [11:0] paddr,
	input wire [31:0] pwdata,
	output reg [31:0] prdata,
	output wire pready,
	output wire pslverr,
	output reg switching_enable,
	output reg quasi_reset,
	output reg [MODE_W-1:0] mode_code,
	output reg refclk_is_125mhz,
	output reg [CLKSEL_W-1:0] port_clocking_mode,
	output reg [STACKS-1:0] stack_config,
	output reg [8:0] mode_flags,
	input wire tck,
	input wire trst_n,
	input wire tms,
	input wire tdi,
	output wire tdo_out,
	output wire tdo_oe
);

	// Sequencer states
	localparam ST_RESET = 2'h0;
	localparam ST_CAPTURE = 2'h1;
	localparam ST_HOLD = 2'h2;
	localparam ST_RUN = 2'h3;

	// Decode of the operating mode into feature flags; used once, at strap capture
	function [8:0] decode_mode;
		input [3:0] code;
		reg [8:0] f;
		begin
			f = 9'h000;
			case (code)
				`MODE_SINGLE: f[`MD_VALID_BIT] = 1'b1; // RULE5
				`MODE_SINGLE_EE: begin // RULE5
					f[`MD_VALID_BIT] = 1'b1;
					f[`MD_EEPROM_BIT] = 1'b1;
				end
				`MODE_JUMP0: begin // RULE5
					f[`MD_VALID_BIT] = 1'b1;
					f[`MD_EEPROM_BIT] = 1'b1;
					f[`MD_JUMP0_BIT] = 1'b1;
				end
				`MODE_JUMP1: begin // RULE5
					f[`MD_VALID_BIT] = 1'b1;
					f[`MD_EEPROM_BIT] = 1'b1;
					f[`MD_JUMP1_BIT] = 1'b1;
				end
				`MODE_LOWLAT: begin // RULE7
					f[`MD_VALID_BIT] = 1'b1;
					f[`MD_LOWLAT_BIT] = 1'b1;
				end
				`MODE_LOWLAT_EE: begin // RULE7
					f[`MD_VALID_BIT] = 1'b1;
					f[`MD_LOWLAT_BIT] = 1'b1;
					f[`MD_EEPROM_BIT] = 1'b1;
				end
				`MODE_UNATT, `MODE_UNATT_I2C, `MODE_UNATT_EE, `MODE_UNATT_I2C_EE: begin // RULE8
					f[`MD_VALID_BIT] = 1'b1;
					f[`MD_MULTI_BIT] = 1'b1;
					f[`MD_UNATT_BIT] = 1'b1;
					f[`MD_I2CRST_BIT] = code[0]; // RULE8
					f[`MD_EEPROM_BIT] = (code >= `MODE_UNATT_EE); // RULE8
				end
				`MODE_DISPORT, `MODE_DISPORT_EE: begin // RULE9
					f[`MD_VALID_BIT] = 1'b1;
					f[`MD_MULTI_BIT] = 1'b1;
					f[`MD_DISPORT_BIT] = 1'b1;
					f[`MD_EEPROM_BIT] = code[0]; // RULE9
				end
				// Reserved 4..7: valid stays low so software can spot a bad strap
				default: f = 9'h000; // RULE6
			endcase
			decode_mode = f;
		end
	endfunction

	reg [1:0] state_r;
	reg [1:0] state_nxt;
	reg hold_bit_r; // Reset-hold bit of the switch control register
	reg hold_latched_r; // Hold strap as seen while reset asserted

	// APB handshake: zero wait state
	wire apb_access = psel & penable;
	wire apb_wr = apb_access & pwrite;
	wire addr_ok = (paddr == `OFS_SWITCH_CONTROL) | (paddr == `OFS_STRAP_STATUS) |
		(paddr == `OFS_MODE_STATUS);
	wire ctl_wr = apb_wr & (paddr == `OFS_SWITCH_CONTROL);
	assign pready = 1'b1;
	assign pslverr = apb_access & ~addr_ok;

	// Next state of the reset sequencer
	always @* begin
		state_nxt = state_r;
		case (state_r)
			ST_RESET: begin
				if (fundamental_reset_n) begin
					state_nxt = ST_CAPTURE;
				end
			end
			ST_CAPTURE: begin
				// Hold strap seen during reset parks the switch
				if (hold_latched_r) begin
					state_nxt = ST_HOLD; // RULE2
				end else begin
					state_nxt = ST_RUN;
				end
			end
			ST_HOLD: begin
				// Leave for run only when software clears the hold bit
				if (ctl_wr && !pwdata[`SWITCH_CONTROL_REG_HOLD_BIT]) begin
					state_nxt = ST_RUN; // RULE4
				end
			end
			ST_RUN: state_nxt = ST_RUN;
			default: state_nxt = ST_RESET;
		endcase
		if (!fundamental_reset_n) begin
			state_nxt = ST_RESET; // RULE1
		end
	end

	// Sequencer and strap capture; fundamental reset acts like nrst
	always @(posedge clk) begin
		if (!nrst || !fundamental_reset_n) begin
			state_r <= ST_RESET; // RULE1
			mode_code <= 4'h0;
			refclk_is_125mhz <= 1'b0;
			port_clocking_mode <= {CLKSEL_W{1'b0}};
			stack_config <= {STACKS{1'b0}};
			mode_flags <= 9'h000;
			// Strap only sampled while reset held, so a late change is ignored
			hold_latched_r <= nrst & reset_hold_strap; // RULE2
		end else begin
			state_r <= state_nxt;
			if (state_r == ST_RESET) begin
				// Straps taken once at release, kept until next reset
				mode_code <= operating_mode_strap; // RULE18
				mode_flags <= decode_mode(operating_mode_strap); // RULE10
				refclk_is_125mhz <= (refclk_freq_select == `REFCLK_125MHZ); // RULE11
				port_clocking_mode <= port_clocking_select; // RULE12
				stack_config <= stack_cfg_strap; // RULE13
			end
		end
	end

	// Switch control hold bit: set by strap, cleared by software
	always @(posedge clk) begin
		if (!nrst || !fundamental_reset_n) begin
			hold_bit_r <= 1'b0; // RULE1
		end else if (state_r == ST_CAPTURE) begin
			hold_bit_r <= hold_latched_r; // RULE2
		end else if (ctl_wr) begin
			// Setting it again after run has no effect on the state
			hold_bit_r <= pwdata[`SWITCH_CONTROL_REG_HOLD_BIT]; // RULE4
		end
	end

	// Status outputs; switching blocked while held
	always @(posedge clk) begin
		if (!nrst || !fundamental_reset_n) begin
			switching_enable <= 1'b0; // RULE1
			quasi_reset <= 1'b0;
		end else begin
			switching_enable <= (state_nxt == ST_RUN); // RULE3
			quasi_reset <= (state_nxt == ST_HOLD); // RULE3
		end
	end

	// Read data, registered during setup; registers live even in quasi-reset
	always @(posedge clk) begin
		if (!nrst) begin
			prdata <= `APB_ERR_DATA;
		end else if (psel && !penable && !pwrite) begin
			case (paddr)
				`OFS_SWITCH_CONTROL: prdata <= {31'h0, hold_bit_r}; // RULE3
				`OFS_STRAP_STATUS: prdata <= {19'h0, (state_r == ST_RUN),
					(state_r == ST_HOLD), stack_config, port_clocking_mode,
					refclk_is_125mhz, mode_code};
				`OFS_MODE_STATUS: prdata <= {23'h0, mode_flags};
				default: prdata <= `APB_ERR_DATA;
			endcase
		end
	end

	// Test-port shift indication, on the test clock only
	reg [3:0] tap_shift_r;
	always @(posedge tck or negedge trst_n) begin
		if (!trst_n) begin
			tap_shift_r <= 4'h0; // RULE16
		end else begin
			// Simple bypass path: shifting while tms low after select
			tap_shift_r <= {tap_shift_r[2:0] & {3{~tms}}, ~tms}; // RULE14
		end
	end
	reg tdi_r;
	always @(posedge tck or negedge trst_n) begin
		if (!trst_n) begin
			tdi_r <= 1'b0; // RULE16
		end else begin
			tdi_r <= tdi;
		end
	end

	test_port_output u_tdo (
		.tck(tck),
		.trst_n(trst_n),
		.shift_active(tap_shift_r[3]),
		.shift_bit(tdi_r),
		.tdo_out(tdo_out),
		.tdo_oe(tdo_oe)
	);

endmodule // reset_and_boot_strap_control

/* hdl/reset_strap_defines.vh */
`ifndef RESET_STRAP_DEFINES_VH
`define RESET_STRAP_DEFINES_VH

// Register byte offsets
`define OFS_SWITCH_CONTROL 12'h000
`define OFS_STRAP_STATUS 12'h004
`define OFS_MODE_STATUS 12'h008

// Switch control fields
`define SWITCH_CONTROL_REG_HOLD_BIT 0

// Strap status fields
`define STS_MODE_LSB 0
`define STS_FREQ_BIT 4
`define STS_CLKSEL_LSB 5
`define STS_STACK_LSB 7
`define STS_QUASI_BIT 11
`define STS_RUN_BIT 12

// Mode status fields
`define MD_VALID_BIT 0
`define MD_EEPROM_BIT 1
`define MD_JUMP0_BIT 2
`define MD_JUMP1_BIT 3
`define MD_LOWLAT_BIT 4
`define MD_MULTI_BIT 5
`define MD_UNATT_BIT 6
`define MD_DISPORT_BIT 7
`define MD_I2CRST_BIT 8

// Operating mode codes
`define MODE_SINGLE 4'h0
`define MODE_SINGLE_EE 4'h1
`define MODE_JUMP0 4'h2
`define MODE_JUMP1 4'h3
`define MODE_LOWLAT 4'h8
`define MODE_LOWLAT_EE 4'h9
`define MODE_UNATT 4'hA
`define MODE_UNATT_I2C 4'hB
`define MODE_UNATT_EE 4'hC
`define MODE_UNATT_I2C_EE 4'hD
`define MODE_DISPORT 4'hE
`define MODE_DISPORT_EE 4'hF

// Reference clock frequency select encodings
`define REFCLK_100MHZ 1'h0
`define REFCLK_125MHZ 1'h1

// Reset values
`define SWITCH_CONTROL_REG_RESET 32'h0000_0000
`define APB_ERR_DATA 32'h0000_0000

`endif

/* hdl/test_port_output.v */
`timescale 1ns/1ps
`include "reset_strap_defines.vh"

// Test-port data output stage, on the test clock alone
module test_port_output (
	input wire tck,
	input wire trst_n,
	input wire shift_active,
	input wire shift_bit,
	output reg tdo_out,
	output reg tdo_oe
);

	// Output changes on falling test clock; async clear from trst_n
	always @(negedge tck or negedge trst_n) begin
		if (!trst_n) begin
			tdo_out <= 1'b0; // RULE16
			tdo_oe <= 1'b0; // RULE16
		end else begin
			tdo_out <= shift_bit; // RULE14
			tdo_oe <= shift_active; // RULE15
		end
	end

endmodule // test_port_output

/* dv/rsc_chk_asserts.sv */
`timescale 1ns/1ps
module rsc_chk #(
	parameter MODE_W = 4
) (
	input wire clk,
	input wire nrst,
	input wire fundamental_reset_n,
	input wire reset_hold_strap,
	input wire [MODE_W-1:0] operating_mode_strap,
	input wire psel,
	input wire penable,
	input wire pwrite,
	input wire [11:0] paddr,
	input wire [31:0] pwdata,
	input wire switching_enable,
	input wire quasi_reset,
	input wire [MODE_W-1:0] mode_code,
	input wire [8:0] mode_flags,
	input wire trst_n,
	input wire tdo_oe
);
	default clocking @(posedge clk); endclocking
	default disable iff (!nrst);
	// Board reset let go, hold strap up
	sequence held_s;
		!fundamental_reset_n && reset_hold_strap ##1 fundamental_reset_n;
	endsequence
	// Software clears the hold bit
	sequence clr_s;
		quasi_reset && psel && penable && pwrite && paddr == 12'h000 && !pwdata[0];
	endsequence
	a_reset_clear: assert property (!fundamental_reset_n |=>
		!switching_enable && !quasi_reset && mode_flags == 9'h000) else $error("reset");
	a_hold_enter: assert property (held_s |-> ##[1:2] quasi_reset) else $error("hold");
	a_hold_quiet: assert property (fundamental_reset_n && quasi_reset && !pwrite |=>
		quasi_reset && !switching_enable) else $error("quiet");
	a_hold_exit: assert property (clr_s ##1 fundamental_reset_n |-> ##[0:1]
		!quasi_reset && switching_enable) else $error("exit");
	a_mode_cap: assert property ($rose(fundamental_reset_n) |-> ##2
		mode_code == operating_mode_strap) else $error("capture");
	a_caps_hold: assert property (fundamental_reset_n [*3] |->
		$stable(mode_code) && $stable(mode_flags)) else $error("stable");
	a_flag_map: assert property (fundamental_reset_n [*3] |->
		mode_flags[5] == (mode_code > 4'h9) && mode_flags[4] == (mode_code[3:1] == 3'h4))
		else $error("flags");
	a_trst_idle: assert property (!trst_n |-> !tdo_oe) else $error("trst");
endmodule // rsc_chk
bind reset_and_boot_strap_control rsc_chk #(.MODE_W(MODE_W)) chk_i (.*);

/* dv/strap_board.sv */
`timescale 1ns/1ps
// Board straps and system reset source
module strap_board (
	input wire clk,
	input wire go,
	input wire [11:0] cfg,
	output reg fundamental_reset_n,
	output reg reset_hold_strap,
	output reg [3:0] operating_mode_strap,
	output reg refclk_freq_select,
	output reg [1:0] port_clocking_select,
	output reg [3:0] stack_cfg_strap
);
	reg [2:0] cnt_r; // Reset cycles left
	// Held in reset until first request
	initial begin
		fundamental_reset_n = 1'b0;
		cnt_r = 3'h0;
	end
	// Straps move only inside a reset pulse, so never after release
	always @(posedge clk) begin
		if (go) begin
			fundamental_reset_n <= 1'b0;
			cnt_r <= 3'h4;
			{reset_hold_strap, operating_mode_strap, refclk_freq_select, port_clocking_select,
				stack_cfg_strap} <= cfg;
		end else if (cnt_r != 3'h0) begin
			cnt_r <= cnt_r - 3'h1;
			fundamental_reset_n <= cnt_r == 3'h1;
		end
	end
endmodule // strap_board

/* dv/reset_and_boot_strap_control_tb.sv */
`timescale 1ns/1ps
module reset_and_boot_strap_control_tb;
	reg clk = 1'b0, nrst = 1'b0, go = 1'b0, psel = 1'b0, penable = 1'b0, pwrite = 1'b0;
	reg tck = 1'b0, tms = 1'b0, tdi = 1'b0;
	reg trst_n = 1'b1; // Pulled low at time zero so the test port clears
	reg [11:0] cfg = 12'h000, paddr = 12'h000;
	reg [31:0] pwdata = 32'h0000_0000;
	wire fundamental_reset_n, reset_hold_strap, refclk_freq_select, pready, pslverr, tdo_out;
	wire switching_enable, quasi_reset, refclk_is_125mhz, tdo_oe;
	wire [3:0] operating_mode_strap, stack_cfg_strap, mode_code, stack_config;
	wire [1:0] port_clocking_select, port_clocking_mode;
	wire [8:0] mode_flags;
	wire [31:0] prdata;
	integer err_count = 0, compares = 0;
	always #10 clk = ~clk; // 50 MHz
	strap_board brd (.*);
	reset_and_boot_strap_control uut (.*);
	task chk(input [31:0] s, input [31:0] e);
		begin
			compares = compares + 1;
			if (s !== e) begin
				err_count = err_count + 1;
				$display("Error %0t seen %h exp %h", $time, s, e);
			end
		end
	endtask
	task end_of_test;
		begin
			$display("compares %0d err_count %0d", compares, err_count);
			if (err_count == 0 && compares > 0)
				$display("ALL CHECKS OK");
			else
				$display("CHECKS NOT OK");
			$finish;
		end
	endtask
	// Bound ran out: count it and stop
	task hang;
		begin
			err_count = err_count + 1;
			end_of_test;
		end
	endtask
	// One APB transfer; q carries pslverr above the read data
	task apb(input w, input [11:0] a, input [31:0] d, output [32:0] q);
		integer n;
		begin
			@(posedge clk);
			psel <= 1'b1;
			pwrite <= w;
			paddr <= a;
			pwdata <= d;
			@(posedge clk);
			penable <= 1'b1;
			n = 0;
			do begin
				@(posedge clk);
				n = n + 1;
			end while (pready !== 1'b1 && n < 9);
			if (pready !== 1'b1)
				hang;
			q = {pslverr, prdata};
			psel <= 1'b0;
			penable <= 1'b0;
		end
	endtask
	// Board reset pulse with new straps
	task boot(input [11:0] c);
		integer n;
		begin
			@(posedge clk);
			cfg <= c;
			go <= 1'b1;
			@(posedge clk);
			go <= 1'b0;
			@(posedge clk);
			#1 chk({quasi_reset, switching_enable}, 0);
			for (n = 0; n < 9 && fundamental_reset_n !== 1'b1; n = n + 1)
				@(posedge clk);
			if (fundamental_reset_n !== 1'b1)
				hang;
			repeat (3) @(posedge clk);
			#1;
		end
	endtask
	// Expected mode flags per code
	function [8:0] fl(input [3:0] m);
		begin
			fl = {m == 4'hB || m == 4'hD, m > 4'hD, m > 4'h9 && m < 4'hE, m > 4'h9,
				m[3:1] == 3'h4, m == 4'h3, m == 4'h2,
				m == 4'h1 || m == 4'h2 || m == 4'h3 || m == 4'h9 || m == 4'hC || m == 4'hD ||
				m == 4'hF, m < 4'h4 || m > 4'h7};
		end
	endfunction
	// Every mode code, other straps but hold varied alongside
	task mode_table;
		integer i;
		reg [32:0] q;
		begin
			for (i = 0; i < 16; i = i + 1) begin
				boot({1'b0, i[3:0], i[0], i[2:1], ~i[3:0]});
				chk({refclk_is_125mhz, port_clocking_mode, stack_config, mode_code},
					{i[0], i[2:1], ~i[3:0], i[3:0]});
				chk({quasi_reset, switching_enable}, 1);
				apb(1'b0, 12'h008, 0, q);
				chk(q[31:0], fl(i[3:0]));
			end
		end
	endtask
	// Held boot, register access, release by software
	task hold_run;
		reg [32:0] q;
		begin
			boot(12'hE05);
			chk({quasi_reset, switching_enable}, 2);
			apb(1'b1, 12'h004, 0, q);
			apb(1'b0, 12'h004, 0, q);
			chk(q[31:0], 32'h0000_0A8C);
			apb(1'b0, 12'h010, 0, q);
			chk(q[32:1], 32'h8000_0000);
			apb(1'b1, 12'h000, 1, q);
			#1 chk({quasi_reset, switching_enable}, 2);
			apb(1'b0, 12'h000, 0, q);
			chk(q, 33'h0_0000_0001);
			apb(1'b1, 12'h000, 0, q);
			repeat (2) @(posedge clk);
			#1 chk({quasi_reset, switching_enable}, 1);
			apb(1'b0, 12'h000, 0, q);
			chk(q, 33'h0_0000_0000);
		end
	endtask
	// Test port held, clocked, then reset with its clock still
	task test_port;
		integer i;
		begin
			for (i = 0; i < 20; i = i + 1) begin
				@(posedge clk);
				tck <= ~tck;
				tdi <= i[1];
				trst_n <= i > 6;
				if (i == 6)
					chk({tdo_oe, tdo_out}, 0);
			end
			@(posedge clk);
			chk(tdo_oe, 1);
			trst_n <= 1'b0;
			@(posedge clk);
			#1 chk({tdo_oe, tdo_out}, 0);
		end
	endtask
	initial begin
		trst_n <= 1'b0;
		repeat (3) @(posedge clk);
		nrst <= 1'b1;
		mode_table;
		hold_run;
		test_port;
		end_of_test;
	end
endmodule // reset_and_boot_strap_control_tb
